//--- rtl/pattern_gen_pkg.sv
//=============================================================================
// Summary of operation
// - Converter pattern swaps samples for fixed 12-bit codes repeating every two samples
// - Foreground lanes 0-7 alternate fixed low codes with their bitwise complements
// - Background calibration gives each bank its own code pair on lanes n, n+4
// - Serializer test mode chosen by four-bit field, bits 3:0 of register 0x202
// - Lane power follows decimation and double-rate settings, never the pattern
// - Pseudo-random modes send raw bits to lanes, skipping the 8b/10b encoder
// - Seven-stage mode: new bit is XOR of bits six and seven back
// - Fifteen-stage taps 14/15, twenty-three-stage taps 18/23, XOR feedback
// - Every lane's pseudo-random generator starts from a distinct phase
// - Ramp mode keeps link layer running, transport off, formatter data dropped
// - After lane alignment every lane sends identical octets counting 0x00 to 0xFF
// - Short transport pattern only at decimation one, one frame long
// - Short sample holds inverted lane index, lane index, sample index plus one
// - Long transport pattern offered in every decimating mode
// - Transport patterns start aligned to the SYSREF event after link enable
// - D21.5 mode sends an unbroken stream of that data character
//=============================================================================
// Purpose : Constants and types of the lane test-pattern generator
// Assumes : Eight lanes, one sample and one symbol per lane per clock
// Notes   : Byte address of an indexed register is four times its index

package pattern_gen_pkg;

   //==========================================================================
   // Geometry
   localparam int NUM_LANES     = 8;
   localparam int SAMPLE_W      = 12;
   localparam int SYM_W         = 10;
   localparam int LFSR_W        = 23;
   localparam int FRAME_SAMPLES = 5;
   localparam int LONG_FRAMES   = 10;
   localparam int NUM_BANKS     = 5;

   //==========================================================================
   // Register map
   localparam logic [11:0] CTRL_ADDR      = 12'h000;
   localparam logic [11:0] STATUS_ADDR    = 12'h004;
   localparam logic [11:0] TEST_SEL_INDEX = 12'h202;
   localparam logic [11:0] TEST_SEL_ADDR  = {TEST_SEL_INDEX[9:0], 2'b00};
   localparam int          CTRL_LINK_BIT  = 0;
   localparam int          CTRL_BGCAL_BIT = 1;
   localparam int          CTRL_DEC1_BIT  = 2;
   localparam int          CTRL_DDR_BIT   = 3;
   localparam logic [3:0]  CTRL_RESET     = 4'h0;
   localparam logic [3:0]  TEST_SEL_RESET = 4'h0;

   //==========================================================================
   // Test selection codes
   localparam logic [3:0] SEL_OFF   = 4'h0;
   localparam logic [3:0] SEL_PRBS_SEVEN_STAGE = 4'h1;
   localparam logic [3:0] SEL_PRBS_FIFTEEN_STAGE = 4'h2;
   localparam logic [3:0] SEL_PRBS_TWENTYTHREE_STAGE = 4'h3;
   localparam logic [3:0] SEL_RAMP  = 4'h4;
   localparam logic [3:0] SEL_SHORT = 4'h5;
   localparam logic [3:0] SEL_LONG  = 4'h6;
   localparam logic [3:0] SEL_D215  = 4'h7;
   localparam logic [3:0] SEL_ADC   = 4'h8;

   //==========================================================================
   // Pattern values
   localparam logic [NUM_LANES-1:0][SAMPLE_W-1:0] FG_LOW = {
      12'h400, 12'h200, 12'h100, 12'h040, 12'h020, 12'h010, 12'h008, 12'h000};
   localparam logic [NUM_BANKS-1:0][SAMPLE_W-1:0] BANK_LOW_N  = {
      12'h020, 12'h010, 12'h008, 12'h004, 12'h000};
   localparam logic [NUM_BANKS-1:0][SAMPLE_W-1:0] BANK_HIGH_N = {
      12'hfdf, 12'hfef, 12'hff7, 12'hffe, 12'hfff};
   localparam logic [NUM_BANKS-1:0][SAMPLE_W-1:0] BANK_LOW_N4 = {
      12'h400, 12'h200, 12'h100, 12'h080, 12'h040};
   localparam logic [NUM_BANKS-1:0][SAMPLE_W-1:0] BANK_HIGH_N4 = {
      12'hbff, 12'hdff, 12'heff, 12'hf7f, 12'hfbf};
   localparam logic [SAMPLE_W-1:0] LONG_IDLE   = 12'h800;
   localparam logic [7:0]          D215_OCTET  = 8'hb5;
   localparam logic [7:0]          RAMP_START  = 8'h00;
   localparam logic [7:0]          PWR_ALL     = 8'hff;
   localparam logic [7:0]          PWR_DDR     = 8'h01;
   localparam logic [7:0]          PWR_SDR     = 8'h03;

   //==========================================================================
   // Types
   typedef enum logic [8:0] {
      M_OFF    = 9'h001,
      M_ADC    = 9'h002,
      M_PRBS_SEVEN_STAGE  = 9'h004,
      M_PRBS_FIFTEEN_STAGE = 9'h008,
      M_PRBS_TWENTYTHREE_STAGE = 9'h010,
      M_RAMP   = 9'h020,
      M_SHORT  = 9'h040,
      M_LONG   = 9'h080,
      M_D215   = 9'h100
   } mode_e;

   typedef struct packed {
      logic             raw;
      logic             k;
      logic [SYM_W-1:0] bits;
   } lane_word_s;

   typedef struct packed {
      logic                                   ack;
      logic [31:0]                            rdata;
      logic [3:0]                             test_sel;
      logic [3:0]                             ctrl;
      mode_e                                  mode;
      logic                                   phase;
      logic [2:0]                             sample_index;
      logic [3:0]                             frame;
      logic [7:0]                             ramp;
      logic [NUM_LANES-1:0][LFSR_W-1:0]       lfsr;
      logic [NUM_LANES-1:0][SAMPLE_W-1:0]     samp;
      lane_word_s [NUM_LANES-1:0]             word;
      logic [7:0]                             pwr;
   } state_s;

endpackage

//--- rtl/lane_test_pattern.sv
//=============================================================================
// Purpose : Lane test-pattern generator with a Wishbone register slave
// Assumes : One sample and one 10-bit symbol per lane per clock
// Notes   : Outputs are registered one cycle after their inputs
`timescale 1ns/1ps
`default_nettype none

module lane_test_pattern (
   // Clock and reset
   input  wire logic                                                   i_ref_clk,
   input  wire logic                                                   i_resetn,
   // Wishbone slave
   input  wire logic                                                   i_wb_cyc,
   input  wire logic                                                   i_wb_stb,
   input  wire logic                                                   i_wb_we,
   input  wire logic [11:0]                                            i_wb_adr,
   input  wire logic [3:0]                                             i_wb_sel,
   input  wire logic [31:0]                                            i_wb_dat,
   output logic                                                        o_wb_ack,
   output logic [31:0]                                                 o_wb_dat,
   // Data path in
   input  wire logic [pattern_gen_pkg::NUM_LANES-1:0][pattern_gen_pkg::SAMPLE_W-1:0] i_lane_sample,
   input  wire logic [pattern_gen_pkg::NUM_LANES-1:0][7:0]             i_link_octet,
   input  wire logic [pattern_gen_pkg::NUM_LANES-1:0]                  i_link_k,
   input  wire logic                                                   i_ila_done,
   input  wire logic                                                   i_sysref,
   input  wire logic [2:0]                                             i_bank_offline,
   // Data path out
   output logic [pattern_gen_pkg::NUM_LANES-1:0][pattern_gen_pkg::SAMPLE_W-1:0] o_lane_sample,
   output pattern_gen_pkg::lane_word_s [pattern_gen_pkg::NUM_LANES-1:0] o_lane_word,
   output logic [7:0]                                                  o_lane_power
);
   import pattern_gen_pkg::*;

   state_s st_r;
   state_s st_nxt;

   //==========================================================================
   // Functions
   function automatic mode_e decode_mode(input logic [3:0] sel, input logic dec1);
      mode_e m;
      m = M_OFF;
      if (sel == SEL_ADC) begin
         m = M_ADC;
      end else if (sel == SEL_PRBS_SEVEN_STAGE) begin
         m = M_PRBS_SEVEN_STAGE;
      end else if (sel == SEL_PRBS_FIFTEEN_STAGE) begin
         m = M_PRBS_FIFTEEN_STAGE;
      end else if (sel == SEL_PRBS_TWENTYTHREE_STAGE) begin
         m = M_PRBS_TWENTYTHREE_STAGE;
      end else if (sel == SEL_RAMP) begin
         m = M_RAMP;
      end else if (sel == SEL_SHORT && dec1) begin
         m = M_SHORT;
      end else if (sel == SEL_LONG && !dec1) begin
         m = M_LONG;
      end else if (sel == SEL_D215) begin
         m = M_D215;
      end
      return m;
   endfunction

   function automatic logic [LFSR_W+SYM_W-1:0] prbs_step(input logic [LFSR_W-1:0] s_in,
                                                        input mode_e m);
      logic [LFSR_W-1:0] s;
      logic [SYM_W-1:0]  w;
      logic              fb;
      s = s_in;
      w = '0;
      for (int i = 0; i < SYM_W; i++) begin
         if (m == M_PRBS_SEVEN_STAGE) begin
            fb = s[5] ^ s[6];
         end else if (m == M_PRBS_FIFTEEN_STAGE) begin
            fb = s[13] ^ s[14];
         end else begin
            fb = s[17] ^ s[22];
         end
         w[SYM_W-1-i] = fb;
         s = {s[LFSR_W-2:0], fb};
      end
      return {s, w};
   endfunction

   function automatic logic [7:0] lane_power(input logic dec1, input logic ddr);
      logic [7:0] p;
      if (dec1) begin
         p = PWR_ALL;
      end else if (ddr) begin
         p = PWR_DDR;
      end else begin
         p = PWR_SDR;
      end
      return p;
   endfunction

   //==========================================================================
   // Next state
   always_comb begin
      logic                  link_en;
      logic                  transport;
      logic [2:0]            base;
      logic [2:0]            bank;
      logic [2:0]            off;
      logic [SAMPLE_W-1:0]   lo;
      logic [SAMPLE_W-1:0]   hi;
      logic [3:0]            sidp1;
      logic [LFSR_W+SYM_W-1:0] step;
      st_nxt    = st_r;
      link_en   = st_r.ctrl[CTRL_LINK_BIT];
      transport = (st_r.mode == M_SHORT) || (st_r.mode == M_LONG);
      off       = (i_bank_offline > 3'(NUM_BANKS-1)) ? 3'(NUM_BANKS-1) : i_bank_offline;
      sidp1     = 4'(st_r.sample_index) + 4'h1;
      base      = '0;
      bank      = '0;
      lo        = '0;
      hi        = '0;
      step      = '0;

      // Bus slave: answer one cycle after the request, commit at the ack edge
      st_nxt.ack = i_wb_cyc && i_wb_stb && !st_r.ack;
      if (st_nxt.ack) begin
         if (i_wb_adr == CTRL_ADDR) begin
            st_nxt.rdata = 32'(st_r.ctrl);
         end else if (i_wb_adr == STATUS_ADDR) begin
            st_nxt.rdata = 32'({st_r.pwr, i_ila_done, st_r.mode});
         end else if (i_wb_adr == TEST_SEL_ADDR) begin
            st_nxt.rdata = 32'(st_r.test_sel);
         end else begin
            st_nxt.rdata = '0;
         end
      end
      if (st_r.ack && i_wb_we && i_wb_sel[0]) begin
         if (i_wb_adr == CTRL_ADDR) begin
            st_nxt.ctrl = i_wb_dat[3:0];
         end else if (i_wb_adr == TEST_SEL_ADDR) begin
            st_nxt.test_sel = i_wb_dat[3:0];
         end
      end

      // Mode follows the selection only while the link is down
      if (!link_en) begin
         st_nxt.mode = decode_mode(st_r.test_sel, st_r.ctrl[CTRL_DEC1_BIT]);
      end

      st_nxt.pwr = lane_power(st_r.ctrl[CTRL_DEC1_BIT], st_r.ctrl[CTRL_DDR_BIT]);

      // Frame counters, phase and ramp
      if (!link_en || (transport && i_sysref)) begin
         st_nxt.sample_index   = '0;
         st_nxt.frame = '0;
         st_nxt.phase = 1'b0;
      end else begin
         st_nxt.phase = !st_r.phase;
         if (st_r.sample_index == 3'(FRAME_SAMPLES-1)) begin
            st_nxt.sample_index   = '0;
            st_nxt.frame = (st_r.frame == 4'(LONG_FRAMES-1)) ? 4'h0 : st_r.frame + 4'h1;
         end else begin
            st_nxt.sample_index = st_r.sample_index + 3'h1;
         end
      end
      if (!link_en || !i_ila_done || st_r.mode != M_RAMP) begin
         st_nxt.ramp = RAMP_START;
      end else begin
         st_nxt.ramp = st_r.ramp + 8'h01;
      end

      // Per-lane data
      for (int l = 0; l < NUM_LANES; l++) begin
         st_nxt.samp[l]      = i_lane_sample[l];
         st_nxt.word[l].raw  = 1'b0;
         st_nxt.word[l].k    = i_link_k[l];
         st_nxt.word[l].bits = {2'b00, i_link_octet[l]};
         if (!link_en || !(st_r.mode inside {M_PRBS_SEVEN_STAGE, M_PRBS_FIFTEEN_STAGE, M_PRBS_TWENTYTHREE_STAGE})) begin
            st_nxt.lfsr[l] = (LFSR_W'(l) << 12) | (LFSR_W'(l) << 4) | LFSR_W'(1);
         end
         case (st_r.mode)
            M_ADC: begin
               if (st_r.ctrl[CTRL_BGCAL_BIT]) begin
                  base = 3'(l % 4);
                  bank = (base < off) ? base : base + 3'h1;
                  lo   = (l >= 4) ? BANK_LOW_N4[bank] : BANK_LOW_N[bank];
                  hi   = (l >= 4) ? BANK_HIGH_N4[bank] : BANK_HIGH_N[bank];
               end else begin
                  lo = FG_LOW[l];
                  hi = ~FG_LOW[l];
               end
               st_nxt.samp[l] = st_r.phase ? hi : lo;
            end
            M_PRBS_SEVEN_STAGE, M_PRBS_FIFTEEN_STAGE, M_PRBS_TWENTYTHREE_STAGE: begin
               if (link_en) begin
                  step                = prbs_step(st_r.lfsr[l], st_r.mode);
                  st_nxt.lfsr[l]      = step[LFSR_W+SYM_W-1:SYM_W];
                  st_nxt.word[l].raw  = 1'b1;
                  st_nxt.word[l].k    = 1'b0;
                  st_nxt.word[l].bits = step[SYM_W-1:0];
               end
            end
            M_RAMP: begin
               st_nxt.samp[l] = '0;
               if (i_ila_done) begin
                  st_nxt.word[l].k    = 1'b0;
                  st_nxt.word[l].bits = {2'b00, st_r.ramp};
               end
            end
            M_SHORT: begin
               st_nxt.samp[l] = {~4'(l), 4'(l), sidp1};
            end
            M_LONG: begin
               st_nxt.samp[l] = (st_r.frame == 4'h0) ? {4'h0, 4'(l), sidp1} : LONG_IDLE;
            end
            M_D215: begin
               st_nxt.word[l].k    = 1'b0;
               st_nxt.word[l].bits = {2'b00, D215_OCTET};
            end
            default: begin
            end
         endcase
      end
   end

   //==========================================================================
   // State register
   always_ff @(posedge i_ref_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         st_r          <= '0;
         st_r.ctrl     <= CTRL_RESET;
         st_r.test_sel <= TEST_SEL_RESET;
         st_r.mode     <= M_OFF;
         st_r.pwr      <= PWR_SDR;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign o_wb_ack      = st_r.ack;
   assign o_wb_dat      = st_r.rdata;
   assign o_lane_sample = st_r.samp;
   assign o_lane_word   = st_r.word;
   assign o_lane_power  = st_r.pwr;

   //==========================================================================
   // Assertions
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_resetn);

   a_pass_through: assert property (
      st_r.mode == M_OFF |=> o_lane_sample == $past(i_lane_sample))
      else $error("Normal data altered with test mode off");
   a_adc_alternate: assert property (
      st_r.mode == M_ADC && st_r.ctrl[CTRL_LINK_BIT] && !st_r.ctrl[CTRL_BGCAL_BIT]
      ##1 st_r.mode == M_ADC && st_r.ctrl[CTRL_LINK_BIT] && !st_r.ctrl[CTRL_BGCAL_BIT]
      |=> o_lane_sample[0] == ~$past(o_lane_sample[0]))
      else $error("Converter pattern did not alternate");
   a_fg_lane_one: assert property (
      st_r.mode == M_ADC && !st_r.ctrl[CTRL_BGCAL_BIT]
      |=> o_lane_sample[1] == 12'h008 || o_lane_sample[1] == 12'hff7)
      else $error("Lane one foreground code wrong");
   a_bank_one_code: assert property (
      st_r.mode == M_ADC && st_r.ctrl[CTRL_BGCAL_BIT] && i_bank_offline == 3'h4
      |=> o_lane_sample[1] == 12'h004 || o_lane_sample[1] == 12'hffe)
      else $error("Bank one code wrong on lane one");
   a_select_write: assert property (
      o_wb_ack && i_wb_we && i_wb_sel[0] && i_wb_adr == 12'h808
      |=> st_r.test_sel == $past(i_wb_dat[3:0]))
      else $error("Test selection write lost");
   a_power_dec1: assert property (
      st_r.ctrl[CTRL_DEC1_BIT] |=> o_lane_power == 8'hff)
      else $error("Lane power not from decimation setting");
   a_prbs_raw: assert property (
      st_r.mode inside {M_PRBS_SEVEN_STAGE, M_PRBS_FIFTEEN_STAGE, M_PRBS_TWENTYTHREE_STAGE} && st_r.ctrl[CTRL_LINK_BIT]
      |=> o_lane_word[0].raw && !o_lane_word[0].k)
      else $error("Pseudo-random word not raw");
   a_prbs_seven_stage_recur: assert property (
      st_r.mode == M_PRBS_SEVEN_STAGE && st_r.ctrl[CTRL_LINK_BIT]
      |=> o_lane_word[3].bits[2] == (o_lane_word[3].bits[8] ^ o_lane_word[3].bits[9])
      && o_lane_word[3].bits[0] == (o_lane_word[3].bits[6] ^ o_lane_word[3].bits[7]))
      else $error("Seven-stage recursion broken");
   a_ramp_count: assert property (
      st_r.mode == M_RAMP && st_r.ctrl[CTRL_LINK_BIT] && i_ila_done [*3]
      |-> o_lane_word[5].bits[7:0] == 8'($past(o_lane_word[5].bits[7:0]) + 8'h01)
      && o_lane_word[5].bits[7:0] == o_lane_word[0].bits[7:0])
      else $error("Ramp octet not counting");
   a_short_first: assert property (
      st_r.mode == M_SHORT && st_r.sample_index == 3'h0 |=> o_lane_sample[0] == 12'hf01
      && o_lane_sample[7] == 12'h871)
      else $error("Short pattern first sample wrong");
   a_sysref_align: assert property (
      st_r.ctrl[CTRL_LINK_BIT] && st_r.mode == M_SHORT && i_sysref ##1 st_r.mode == M_SHORT
      |=> o_lane_sample[2] == 12'hd21)
      else $error("Pattern not aligned to sysref");
   a_d215_stream: assert property (
      st_r.mode == M_D215 |=> o_lane_word[4].bits == 10'h0b5 && !o_lane_word[4].k)
      else $error("D21.5 stream broken");

   c_prbs_twentythree_stage_run:  cover property (st_r.mode == M_PRBS_TWENTYTHREE_STAGE [*4]);
   c_ramp_wrap:   cover property (st_r.mode == M_RAMP && st_r.ramp == 8'hff);
   c_bank_swap:   cover property (st_r.mode == M_ADC && st_r.ctrl[CTRL_BGCAL_BIT] && $changed(i_bank_offline));
   c_long_frame:  cover property (st_r.mode == M_LONG && st_r.frame == 4'h9);

endmodule

`default_nettype wire

//--- sim/lane_receiver_model.sv
// Purpose : Receiver model that self-synchronises to raw lane bits
// Assumes : Line bit 9 of each word is sent first
// Notes   : Counts bits that break the selected two-tap recursion
`timescale 1ns/1ps
`default_nettype none
module lane_receiver_model (
   // Clock and reset
   input  wire logic                                                          i_ref_clk,
   input  wire logic                                                          i_resetn,
   // Lanes from the generator
   input  wire pattern_gen_pkg::lane_word_s [pattern_gen_pkg::NUM_LANES-1:0] i_lane_word,
   // Checker setup
   input  wire logic [4:0]                                                    i_tap_a,
   input  wire logic [4:0]                                                    i_tap_b,
   input  wire logic                                                          i_clear,
   // Result
   output logic [15:0]                                                        o_err_count
);
   import pattern_gen_pkg::*;
   logic [NUM_LANES-1:0][22:0] hist_r;
   int                         seen_r [NUM_LANES];
   //==========================================================================
   // Bit checker
   always @(posedge i_ref_clk or negedge i_resetn) begin
      logic b;
      if (!i_resetn || i_clear) begin
         o_err_count = '0;
         for (int l = 0; l < NUM_LANES; l++) seen_r[l] = 0;
      end else begin
         for (int l = 0; l < NUM_LANES; l++) begin
            for (int i = SYM_W - 1; i >= 0; i--) begin
               b = i_lane_word[l].bits[i];
               if (!i_lane_word[l].raw) seen_r[l] = 0;
               else if (seen_r[l] >= 24 && b !== (hist_r[l][i_tap_a-1] ^ hist_r[l][i_tap_b-1])) o_err_count++;
               hist_r[l] = {hist_r[l][21:0], b};
               seen_r[l]++;
            end
         end
      end
   end
endmodule
`default_nettype wire

//--- sim/tb.sv
// Purpose : Self-checking bench of the lane test-pattern generator
// Assumes : Register map and select codes of the package
// Notes   : Inputs move on rising edges, lane outputs are read on falling edges, bus ack and read data on rising edges
`timescale 1ns/1ps
`default_nettype none
module tb;
   import pattern_gen_pkg::*;
   logic                               clk = 0, resetn = 0, cyc = 0, stb = 0, we = 0, ila = 0, sysref = 0;
   logic [11:0]                        adr = '0;
   logic [3:0]                         sel = '0;
   logic [31:0]                        dat = '0, q, rdat;
   logic [NUM_LANES-1:0][SAMPLE_W-1:0] samp = '0, osamp;
   logic [NUM_LANES-1:0][7:0]          octet = '0;
   logic [NUM_LANES-1:0]               kk = '0;
   logic [2:0]                         bank = '0;
   logic [4:0]                         tap_a = 5'h06, tap_b = 5'h07;
   logic                               rx_clear = 1, ack;
   lane_word_s [NUM_LANES-1:0]         oword;
   logic [7:0]                         pwr;
   logic [15:0]                        rx_err;
   int                                 mismatches = 0, check_count = 0;
   always #20 clk = ~clk;
   lane_test_pattern DUT (.i_ref_clk(clk), .i_resetn(resetn), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
      .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat), .o_wb_ack(ack), .o_wb_dat(rdat), .i_lane_sample(samp),
      .i_link_octet(octet), .i_link_k(kk), .i_ila_done(ila), .i_sysref(sysref), .i_bank_offline(bank),
      .o_lane_sample(osamp), .o_lane_word(oword), .o_lane_power(pwr));
   lane_receiver_model rx (.i_ref_clk(clk), .i_resetn(resetn), .i_lane_word(oword), .i_tap_a(tap_a),
      .i_tap_b(tap_b), .i_clear(rx_clear), .o_err_count(rx_err));
   //==========================================================================
   // Shared tasks
   task automatic close_out();
      $display("mismatches %0d checks %0d", mismatches, check_count);
      if (mismatches == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("mismatch %s expected %h seen %h", name, exp, got);
         mismatches++;
      end
   endtask
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1;
      stb <= 1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'h1;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = rdat;
      cyc <= 0;
      stb <= 0;
      @(posedge clk);
      if (n >= 20) begin
         mismatches++;
         close_out();
      end
   endtask
   task automatic set_mode(input logic [3:0] s, input logic [3:0] c);
      wb(1, CTRL_ADDR, {28'h0, c & 4'he});
      wb(1, TEST_SEL_ADDR, {28'h0, s});
      @(posedge clk);
      wb(1, CTRL_ADDR, {28'h0, c | 4'h1});
      repeat (2) @(posedge clk);
   endtask
   //==========================================================================
   // Scenarios
   task automatic t_regs();
      wb(0, TEST_SEL_ADDR, 0);
      chk("sel reset", 0, q);
      wb(1, TEST_SEL_ADDR, 32'h5);
      wb(0, TEST_SEL_ADDR, 0);
      chk("sel field", 32'h5, q);
      wb(0, 12'h100, 0);
      chk("unmapped", 0, q);
   endtask
   task automatic t_off(input logic [3:0] s, input logic [3:0] c);
      set_mode(s, c);
      for (int l = 0; l < NUM_LANES; l++) begin
         samp[l] <= {8'h3a, 1'b0, 3'(l)};
         octet[l] <= {5'h0a, 3'(l)};
      end
      kk <= 8'h81;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("lane power", c[2] ? 8'hff : (c[3] ? 8'h01 : 8'h03), pwr);
      for (int l = 0; l < NUM_LANES; l++) begin
         chk("pass sample", samp[l], osamp[l]);
         chk("pass word", {1'b0, kk[l], octet[l]}, {oword[l].raw, oword[l].k, oword[l].bits[7:0]});
      end
   endtask
   task automatic t_adc();
      logic [NUM_LANES-1:0][SAMPLE_W-1:0] s0;
      logic [SAMPLE_W-1:0]                lo;
      set_mode(SEL_ADC, 4'h4);
      @(negedge clk);
      s0 = osamp;
      @(negedge clk);
      for (int l = 0; l < NUM_LANES; l++) begin
         lo = FG_LOW[l];
         chk("fg pair", (s0[l] === lo) ? {lo, ~lo} : {~lo, lo}, {s0[l], osamp[l]});
      end
      wb(1, CTRL_ADDR, 32'h7);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("bank1 lane0", 1, osamp[0] === 12'h004 || osamp[0] === 12'hffe);
      chk("bank1 lane4", 1, osamp[4] === 12'h080 || osamp[4] === 12'hf7f);
      @(posedge clk);
      bank <= 3'h1;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk("bank0 lane0", 1, osamp[0] === 12'h000 || osamp[0] === 12'hfff);
   endtask
   task automatic t_prbs(input logic [3:0] s, input logic [4:0] a, input logic [4:0] b);
      tap_a <= a;
      tap_b <= b;
      rx_clear <= 1;
      wb(1, CTRL_ADDR, 32'h8);
      wb(1, TEST_SEL_ADDR, {28'h0, s});
      @(posedge clk);
      wb(1, CTRL_ADDR, 32'h9);
      @(negedge clk);
      for (int l = 0; l < NUM_LANES; l++) begin
         chk("raw lane", 1, oword[l].raw);
         for (int m = l + 1; m < NUM_LANES; m++) chk("lane phase", 1, oword[l].bits !== oword[m].bits);
      end
      @(posedge clk);
      rx_clear <= 0;
      repeat (200) @(posedge clk);
      @(negedge clk);
      chk("prbs errors", 0, rx_err);
   endtask
   task automatic t_ramp();
      int n;
      ila <= 0;
      octet <= {8{8'h3c}};
      set_mode(SEL_RAMP, 4'h4);
      @(negedge clk);
      chk("ramp link", 8'h3c, oword[3].bits[7:0]);
      chk("ramp samples", 0, |osamp);
      @(posedge clk);
      ila <= 1;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (oword[0].bits[7:0] !== 8'h00 && n < 8);
      for (int t = 0; t < 260; t++) begin
         for (int l = 0; l < NUM_LANES; l++) chk("ramp octet", t[7:0], oword[l].bits[7:0]);
         @(negedge clk);
      end
   endtask
   task automatic t_tpl(input logic [3:0] s, input logic [3:0] c, input int frames);
      logic [11:0] e;
      set_mode(s, c);
      sysref <= 1;
      @(posedge clk);
      sysref <= 0;
      @(posedge clk);
      @(negedge clk);
      for (int t = 0; t < 5 * frames + 5; t++) begin
         for (int l = 0; l < NUM_LANES; l++) begin
            if (s == SEL_SHORT) e = {~4'(l), 4'(l), 4'(t % 5 + 1)};
            else e = ((t / 5) % 10 == 0) ? {4'h0, 4'(l), 4'(t % 5 + 1)} : LONG_IDLE;
            chk("transport sample", e, osamp[l]);
         end
         @(negedge clk);
      end
   endtask
   task automatic t_d215();
      set_mode(SEL_D215, 4'h0);
      repeat (4) begin
         @(negedge clk);
         for (int l = 0; l < NUM_LANES; l++) chk("d215 word", 10'h0b5, {oword[l].raw, oword[l].k, oword[l].bits[7:0]});
      end
      @(posedge clk);
      wb(1, TEST_SEL_ADDR, {28'h0, SEL_PRBS_SEVEN_STAGE});
      wb(0, STATUS_ADDR, 0);
      chk("mode held", 9'h100, q[8:0]);
      chk("status power", 8'h03, q[17:10]);
   endtask
   //==========================================================================
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      chk("reset power", 8'h03, pwr);
      chk("reset ack", 0, ack);
      resetn <= 1;
      @(posedge clk);
      t_regs();
      t_off(SEL_OFF, 4'h4);
      t_off(SEL_SHORT, 4'h8);
      t_off(SEL_LONG, 4'h4);
      t_adc();
      t_prbs(SEL_PRBS_SEVEN_STAGE, 5'h06, 5'h07);
      t_prbs(SEL_PRBS_FIFTEEN_STAGE, 5'h0e, 5'h0f);
      t_prbs(SEL_PRBS_TWENTYTHREE_STAGE, 5'h12, 5'h17);
      t_ramp();
      t_tpl(SEL_SHORT, 4'h4, 2);
      t_tpl(SEL_LONG, 4'h0, 10);
      t_d215();
      close_out();
   end
   initial begin
      repeat (100000) @(posedge clk);
      mismatches++;
      close_out();
   end
endmodule
`default_nettype wire
